/* File: design/access_port_defs.vh */
`ifndef ACCESS_PORT_DEFS_VH
`define ACCESS_PORT_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// word offsets inside the 256-byte access port register space
`define OFS_CTRL_STATUS  8'hFC
`define OFS_XFER_ADDR    8'h04
`define OFS_DATA_RW      8'h0C
`define OFS_BANK0        8'h10
`define OFS_BANK1        8'h14
`define OFS_BANK2        8'h18
`define OFS_BANK3        8'h1C
`define OFS_CONFIG       8'hF4
`define OFS_DEBUG_BASE   8'hF8
`define OFS_IDENTITY     8'hFC
`define OFS_CSW          8'h00
`define OFS_WORD_MASK    8'hFC

////////////////////////////////////////////////////////////////////////////////
// identity word field positions
`define ID_REV_HI        31
`define ID_REV_LO        28
`define ID_CONT_HI       27
`define ID_CONT_LO       24
`define ID_CODE_HI       23
`define ID_CODE_LO       17
`define ID_CLASS_BIT     16
`define ID_RSVD_HI       15
`define ID_RSVD_LO       8
`define ID_VAR_HI        7
`define ID_VAR_LO        4
`define ID_TYPE_HI       3
`define ID_TYPE_LO       0

// connection types
`define TYPE_SCAN_CHAIN  4'h0
`define TYPE_SYSTEM_BUS  4'h1
`define TYPE_PERIPH_BUS  4'h2
`define VARIANT_MIN      4'h1

////////////////////////////////////////////////////////////////////////////////
// control/status word fields and reset values
`define CSW_SIZE_HI      2
`define CSW_SIZE_LO      0
`define CSW_INC_HI       5
`define CSW_INC_LO       4
`define CSW_SIZE_WORD    3'h2
`define CSW_INC_OFF      2'h0
`define CSW_INC_SINGLE   2'h1
`define TAR_RESET        32'h0000_0000
`define TAR_STEP         32'h0000_0004
`define WORD_ZERO        32'h0000_0000

// bus answer
`define RESP_OKAY        2'h0

`endif

/* File: design/access_port_regs.v */
`timescale 1ns/10ps
`include "access_port_defs.vh"

module access_port_regs #(
  parameter        ADDR_W        = 8,             // byte address width of the port space
  parameter        MEM_AW        = 4,             // word address width of the backing store
  parameter [3:0]  REVISION      = 4'h0,          // design revision
  parameter [3:0]  DESIGNER_CONT = 4'h9,          // arbitrary value
  parameter [6:0]  DESIGNER_CODE = 7'h15,         // arbitrary value
  parameter [3:0]  VARIANT       = 4'h1,          // variant nibble
  parameter [3:0]  CONN_TYPE     = 4'h1,          // connection type nibble
  parameter        PRESENT       = 1,             // zero makes the whole space read zero
  parameter [31:0] CONFIG_VALUE  = 32'h0000_0000, // configuration word
  parameter [31:0] BASE_VALUE    = 32'h0000_0000  // debug base address word
) (
  input  wire              CLK,     // clock, 100 MHz
  input  wire              RST,     // asynchronous reset, active high
  input  wire [ADDR_W-1:0] AWADDR,  // write address
  input  wire              AWVALID, // write address valid
  output wire              AWREADY, // write address ready
  input  wire [31:0]       WDATA,   // write data
  input  wire [3:0]        WSTRB,   // write byte strobes
  input  wire              WVALID,  // write data valid
  output wire              WREADY,  // write data ready
  output wire [1:0]        BRESP,   // write response
  output wire              BVALID,  // write response valid
  input  wire              BREADY,  // write response ready
  input  wire [ADDR_W-1:0] ARADDR,  // read address
  input  wire              ARVALID, // read address valid
  output wire              ARREADY, // read address ready
  output wire [31:0]       RDATA,   // read data
  output wire [1:0]        RRESP,   // read response
  output wire              RVALID,  // read data valid
  input  wire              RREADY   // read data ready
);

  localparam DEPTH = 1 << MEM_AW;

  ////////////////////////////////////////////////////////////////////////////
  // port register map, one aligned 32-bit word per offset:
  //   0x00 control/status, 0x04 transfer address, 0x0C data window
  //   0x10 to 0x1C banked slots, 0xF4 configuration, 0xF8 debug base
  //   0xFC identity word, the one register every port type carries
  // all but the identity word exist only for the memory-access class;
  // every other offset reads zero and drops its writes, so a debugger
  // probing the space never sees stale data from an unused slot
  // address bits above the 256-byte space fold away, so the map repeats

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [7:0]  aw_off_q;
  reg         aw_held_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_held_q;
  reg         bvalid_q;
  reg  [31:0] rdata_q;
  reg         rvalid_q;
  reg  [31:0] tar_q;
  reg  [31:0] tar_d;
  reg  [1:0]  inc_q;
  reg  [1:0]  inc_d;
  reg  [31:0] mem_q [0:DEPTH-1];
  reg  [31:0] rd_val;
  reg         mem_we;
  reg  [MEM_AW-1:0] mem_wi;
  reg  [MEM_AW-1:0] mem_ri;
  reg         rd_data_hit;
  wire [31:0] id_word;
  wire        is_mem;
  wire        wr_fire;
  wire        rd_fire;
  wire        aw_take;
  wire        w_take;
  wire [7:0]  ar_off;
  wire [31:0] csw_word;
  wire [31:0] tar_next_inc;
  integer     i;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // word-aligned offset inside the 256-byte space; bits above it fold away
  // the low two address bits are dropped: every register is one aligned word
  function [7:0] word_off;
    input [ADDR_W-1:0] a;
    reg   [7:0]        wide;
    begin
      wide     = 8'h00;
      wide     = a[7:0];
      word_off = wide & `OFS_WORD_MASK;
    end
  endfunction

  // store index for a data or banked access; banked slots share the
  // upper address bits of the transfer address
  // a transfer address past the end of the store wraps onto its low words
  function [MEM_AW-1:0] store_index;
    input [31:0] tar;
    input [7:0]  off;
    begin
      if (off == `OFS_DATA_RW) begin
        store_index = tar[MEM_AW+1:2];
      end else begin
        store_index = {tar[MEM_AW+1:4], off[3:2]};
      end
    end
  endfunction

  // true for the data window and the four banked slots
  // these five offsets are the only ones that reach the store
  function is_data_off;
    input [7:0] off;
    begin
      is_data_off = (off == `OFS_DATA_RW) || (off == `OFS_BANK0) ||
                    (off == `OFS_BANK1) || (off == `OFS_BANK2) ||
                    (off == `OFS_BANK3);
    end
  endfunction

  // merge a write under byte strobes
  // a byte whose strobe is low keeps its old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[8*b +: 8] = nw[8*b +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // identity word, fixed at build time
  // it has no write path at all, so a bus write can never change it
  identity_word #(
    .REVISION      (REVISION),
    .DESIGNER_CONT (DESIGNER_CONT),
    .DESIGNER_CODE (DESIGNER_CODE),
    .VARIANT       (VARIANT),
    .CONN_TYPE     (CONN_TYPE),
    .PRESENT       (PRESENT)
  ) u_identity (
    .id_word (id_word),
    .is_mem  (is_mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus timing seen from the master, edge 0 being the edge that takes a request:
  //   write: the later half taken at edge 0, the write lands at edge 1 and BVALID
  //          stands from edge 1 until the edge at which BREADY is high
  //   read:  address taken at edge 0, RVALID and RDATA stand from edge 0 until
  //          the edge at which RREADY is high
  //   a read is held off for the one cycle in which a write lands, which
  //   costs at most one cycle but keeps data-window steps in order
  // bus handshakes: each address/data channel is taken once and held
  // until the write is done, so the two may arrive in either order
  assign AWREADY = ~aw_held_q & ~bvalid_q;
  assign WREADY  = ~w_held_q & ~bvalid_q;
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  // a channel is taken at the edge where its valid meets its ready
  assign aw_take = AWVALID & AWREADY;
  assign w_take  = WVALID & WREADY;
  // reads wait out a write in progress so data-window side effects never collide
  assign ARREADY = ~rvalid_q & ~wr_fire;
  assign rd_fire = ARVALID & ARREADY;
  assign ar_off  = word_off(ARADDR);

  assign BVALID = bvalid_q;
  assign BRESP  = `RESP_OKAY;  // every offset answers okay, reserved ones included
  assign RVALID = rvalid_q;
  assign RDATA  = rdata_q;
  assign RRESP  = `RESP_OKAY;

  // control/status view: size fixed at word, increment mode writable
  assign csw_word = {26'h000_0000, inc_q, 1'b0, `CSW_SIZE_WORD};
  assign tar_next_inc = tar_q + `TAR_STEP;

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture
  // both halves are held until the response, so no buffer is needed
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_off_q  <= 8'h00;
      aw_held_q <= 1'b0;
      wdata_q   <= `WORD_ZERO;
      wstrb_q   <= 4'h0;
      w_held_q  <= 1'b0;
      bvalid_q  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_off_q  <= word_off(AWADDR);
        aw_held_q <= 1'b1;
      end
      if (w_take) begin
        wdata_q  <= WDATA;
        wstrb_q  <= WSTRB;
        w_held_q <= 1'b1;
      end
      // response one cycle after both halves are in
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
      end else if (bvalid_q && BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode for writes and for data-window reads; the memory-access
  // set exists only when the port is present and of a bus connection type
  always @* begin
    tar_d       = tar_q;
    inc_d       = inc_q;
    mem_we      = 1'b0;
    mem_wi      = store_index(tar_q, aw_off_q);
    mem_ri      = store_index(tar_q, ar_off);
    rd_data_hit = 1'b0;
    if (wr_fire && is_mem) begin
      case (aw_off_q)
        `OFS_CSW: begin
          if (wstrb_q[0]) begin
            inc_d = wdata_q[`CSW_INC_HI:`CSW_INC_LO];
          end
        end
        `OFS_XFER_ADDR: begin
          tar_d = merge(tar_q, wdata_q, wstrb_q);
        end
        `OFS_DATA_RW, `OFS_BANK0, `OFS_BANK1, `OFS_BANK2, `OFS_BANK3: begin
          mem_we = 1'b1;
          // only the data window steps the address; banked slots never do
          if ((aw_off_q == `OFS_DATA_RW) && (inc_q == `CSW_INC_SINGLE)) begin
            tar_d = tar_next_inc;
          end
        end
        // identity, configuration, base and reserved: write ignored
        default: begin
          tar_d = tar_q;
        end
      endcase
    end else if (rd_fire && is_mem && is_data_off(ar_off)) begin
      // a read of the data window is itself an access and may step the address
      rd_data_hit = 1'b1;
      if ((ar_off == `OFS_DATA_RW) && (inc_q == `CSW_INC_SINGLE)) begin
        tar_d = tar_next_inc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read value decode; store data is only offered when the read really
  // fires, so a read of the window is always one access with at most one step
  always @* begin
    rd_val = `WORD_ZERO;
    if (ar_off == `OFS_IDENTITY) begin
      rd_val = id_word;
    end else if (is_mem) begin
      case (ar_off)
        `OFS_CSW:        rd_val = csw_word;
        `OFS_XFER_ADDR:  rd_val = tar_q;
        `OFS_CONFIG:     rd_val = CONFIG_VALUE;
        `OFS_DEBUG_BASE: rd_val = BASE_VALUE;
        default: begin
          if (rd_data_hit) begin
            rd_val = mem_q[mem_ri];
          end else begin
            rd_val = `WORD_ZERO;
          end
        end
      endcase
    end else begin
      rd_val = `WORD_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: data registered at the same edge that takes the address
  // RDATA then stands unchanged until the master takes it
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_q  <= `WORD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      if (rd_fire) begin
        rdata_q  <= rd_val;
        rvalid_q <= 1'b1;
      end else if (rvalid_q && RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control state of the memory-access set
  // reserved increment modes are kept as written but never step the address
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      tar_q <= `TAR_RESET;
      inc_q <= `CSW_INC_OFF;
    end else begin
      tar_q <= tar_d;
      inc_q <= inc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // backing store behind the data window; cleared on reset so reads of
  // untouched words are defined, at the cost of a wide reset fan-out
  // the store stands in for the memory system that a full port would drive
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= `WORD_ZERO;
      end
    end else if (mem_we) begin
      mem_q[mem_wi] <= merge(mem_q[mem_wi], wdata_q, wstrb_q);
    end
  end

endmodule // access_port_regs

/* File: design/identity_word.v */
`timescale 1ns/10ps
`include "access_port_defs.vh"

// builds the read-only identity word from the build-time values
module identity_word #(
  parameter [3:0] REVISION      = 4'h0,
  parameter [3:0] DESIGNER_CONT = 4'h9,    // arbitrary value
  parameter [6:0] DESIGNER_CODE = 7'h15,   // arbitrary value
  parameter [3:0] VARIANT       = 4'h1,
  parameter [3:0] CONN_TYPE     = 4'h1,
  parameter       PRESENT       = 1
) (
  output wire [31:0] id_word,  // assembled identity word
  output wire        is_mem    // port is present and of a bus connection type
);

  ////////////////////////////////////////////////////////////////////////////
  // class follows the connection type, except that the legacy encoding forces the class bit to zero
  wire       bus_type = (CONN_TYPE == `TYPE_SYSTEM_BUS) ||
                        (CONN_TYPE == `TYPE_PERIPH_BUS);
  wire       scan     = (CONN_TYPE == `TYPE_SCAN_CHAIN);
  // a scan-chain port may not show variant zero; lift it to the least legal one
  wire [3:0] variant  = (scan && (VARIANT == 4'h0)) ? `VARIANT_MIN : VARIANT;
  // an all-zero designer code is the legacy encoding, which also shows zero
  // revision and class; a compliant build sets a real code and never lands here
  wire       legacy   = (DESIGNER_CONT == 4'h0) && (DESIGNER_CODE == 7'h00);
  wire [31:0] word;

  // assemble the fields; reserved byte is zero
  assign word[`ID_REV_HI:`ID_REV_LO]   = legacy ? 4'h0 : REVISION;
  assign word[`ID_CONT_HI:`ID_CONT_LO] = DESIGNER_CONT;
  assign word[`ID_CODE_HI:`ID_CODE_LO] = DESIGNER_CODE;
  assign word[`ID_CLASS_BIT]           = bus_type & ~legacy;
  assign word[`ID_RSVD_HI:`ID_RSVD_LO] = 8'h00;
  assign word[`ID_VAR_HI:`ID_VAR_LO]   = variant;
  assign word[`ID_TYPE_HI:`ID_TYPE_LO] = CONN_TYPE;

  // an absent port answers all zeros
  assign id_word = (PRESENT != 0) ? word : `WORD_ZERO;
  assign is_mem  = (PRESENT != 0) && bus_type;

endmodule // identity_word

/* File: verification/access_port_id_register_tb_top.sv */
`timescale 1ns/10ps
module access_port_id_register_tb_top;
  localparam [3:0]  REV = 4'h2, CONT = 4'h9, VAR = 4'h3, CTYPE = 4'h2; // designer values arbitrary
  localparam [6:0]  CODE = 7'h15;                                        // arbitrary value
  localparam [31:0] CFG_V = 32'h0000_0001, BASE_V = 32'h0000_5003;
  localparam [31:0] ID_EXP = {REV, CONT, CODE, CTYPE == 4'h1 || CTYPE == 4'h2, 8'h00, VAR, CTYPE};
  reg         CLK = 1'b0;
  reg         RST = 1'b1;
  wire [7:0]  AWADDR, ARADDR;
  wire [31:0] WDATA, RDATA;
  wire [3:0]  WSTRB;
  wire [1:0]  BRESP;
  wire        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  integer     fail_count = 0;
  integer     checks = 0;
  integer     i;
  reg  [31:0] r, tar, last_rd;
  reg  [31:0] mem [0:15];
  reg  [1:0]  inc;

  always #5 CLK = ~CLK;
  //////////////////////////////////////////////////////////////////////////////
  access_port_regs #(.REVISION(REV), .DESIGNER_CONT(CONT), .DESIGNER_CODE(CODE), .VARIANT(VAR),
    .CONN_TYPE(CTYPE), .CONFIG_VALUE(CFG_V), .BASE_VALUE(BASE_V)) DUT (
    .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(), .RVALID(RVALID), .RREADY(RREADY));
  dbg_port_model DP (
    .CLK(CLK), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY));
  //////////////////////////////////////////////////////////////////////////////
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // one bus access mirrored in the model; the window store wraps at 16 words like the block's
  task access(input wr, input [7:0] a, input [31:0] d);
    reg [31:0] q, got;
    reg [3:0]  idx;
    begin
      q = 32'h0000_0000;
      case (a & 8'hFC)
        8'hFC: q = ID_EXP;
        8'h00: begin
          if (wr) inc = d[5:4];
          q = {26'h0, inc, 4'h2};
        end
        8'h04: begin
          if (wr) tar = d;
          q = tar;
        end
        8'h0C: begin
          idx = tar[5:2];
          if (wr) mem[idx] = d;
          q = mem[idx];
          if (inc == 2'h1) tar = tar + 32'h0000_0004;
        end
        8'h10, 8'h14, 8'h18, 8'h1C: begin
          idx = {tar[5:4], a[3:2]};
          if (wr) mem[idx] = d;
          q = mem[idx];
        end
        8'hF4: q = CFG_V;
        8'hF8: q = BASE_V;
        default: q = 32'h0000_0000;
      endcase
      DP.xfer(wr, a, d, got);
      if (DP.hang) begin
        fail_count = fail_count + 1;
        $display("BAD %0t bus transfer timed out", $time);
        give_verdict;
      end else if (!wr) begin
        last_rd = got;
        check(got, q);
      end
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    r = $urandom(29271);
    for (i = 0; i < 16; i = i + 1) mem[i] = 32'h0000_0000;
    {tar, inc} = 34'h0;
    last_rd = 32'h0000_0000;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    // reset values of the memory-access set before anything is written
    access(1'b0, 8'h04, 32'h0000_0000);
    access(1'b0, 8'h00, 32'h0000_0000);
    // identity word, a write aimed at it, then a read with stray low address bits
    access(1'b0, 8'hFC, 32'h0000_0000);
    access(1'b1, 8'hFC, $urandom);
    access(1'b0, 8'hFF, 32'h0000_0000);
    check({31'h0, DP.port_present(last_rd)}, 32'h0000_0001);
    check({31'h0, DP.origin_designer(last_rd)}, 32'h0000_0000);
    $display("identity test done");
    // every word of the space written with noise, then read back
    for (i = 0; i < 64; i = i + 1) begin
      access(1'b1, {i[5:0], 2'b00}, $urandom);
      access(1'b0, {i[5:0], 2'b00}, 32'h0000_0000);
    end
    $display("full map test done");
    // stepping window across the wrap of the store, then read through the banked slots
    access(1'b1, 8'h00, 32'h0000_0010);
    access(1'b1, 8'h04, 32'h0000_0038);
    for (i = 0; i < 4; i = i + 1) access(1'b1, 8'h0C, $urandom);
    access(1'b0, 8'h04, 32'h0000_0000);
    for (i = 0; i < 8; i = i + 1) access(1'b0, {i[1:0], 2'b00} + (i < 4 ? 8'h10 : 8'h30), 32'h0000_0000);
    for (i = 0; i < 4; i = i + 1) access(1'b0, 8'h0C, 32'h0000_0000);
    $display("window test done");
    // random back-to-back mix over the whole space
    for (i = 0; i < 80; i = i + 1) begin
      r = $urandom;
      access(r[0], r[1] ? r[15:8] : {3'h0, r[4:2], 2'h0}, $urandom);
    end
    $display("random test done");
    give_verdict;
  end
endmodule // access_port_id_register_tb_top

/* File: verification/ap_id_monitor.sv */
`timescale 1ns/10ps
module access_port_monitor #(
  parameter       ADDR_W        = 8,
  parameter [3:0] REVISION      = 4'h0,
  parameter [3:0] DESIGNER_CONT = 4'h9,  // arbitrary value
  parameter [6:0] DESIGNER_CODE = 7'h15, // arbitrary value
  parameter [3:0] VARIANT       = 4'h1,
  parameter [3:0] CONN_TYPE     = 4'h1
) (
  input wire              CLK,     // clock
  input wire              RST,     // reset
  input wire [ADDR_W-1:0] ARADDR,  // read address
  input wire              ARVALID, // read request
  input wire              ARREADY, // read taken
  input wire [31:0]       RDATA,   // read data
  input wire              RVALID,  // read answer
  input wire [1:0]        RRESP,   // read code
  input wire              AWVALID, // write address
  input wire              AWREADY, // address taken
  input wire              WVALID,  // write data
  input wire              WREADY,  // data taken
  input wire [1:0]        BRESP,   // write code
  input wire              BVALID   // write answer
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  //////////////////////////////////////////////////////////////////////////////
  // word index of the read in flight, so an answer is judged by where it came from
  reg  [5:0] rd_word_q;
  wire       id_seen = RVALID && rd_word_q == 6'h3F;
  always @(posedge CLK or posedge RST) begin
    if (RST) rd_word_q <= 6'h00;
    else if (ARVALID && ARREADY) rd_word_q <= ARADDR[7:2];
  end
  //////////////////////////////////////////////////////////////////////////////
  chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read not answered next cycle");
  chk_rev_field: assert property (id_seen |-> RDATA[31:28] == REVISION)
    else $error("revision field wrong");
  chk_designer_id: assert property (id_seen |-> RDATA[27:17] == {DESIGNER_CONT, DESIGNER_CODE})
    else $error("designer code wrong");
  chk_class_bit: assert property (id_seen |-> RDATA[16] == (RDATA[3:0] == 4'h1 || RDATA[3:0] == 4'h2))
    else $error("class bit does not match type");
  chk_impl_byte: assert property (id_seen |-> RDATA[7:0] == {VARIANT, CONN_TYPE})
    else $error("implementation byte wrong");
  chk_id_resv_byte: assert property (id_seen |-> RDATA[15:8] == 8'h00 && RDATA != 32'h0000_0000)
    else $error("identity middle byte or presence wrong");
  chk_resv_raz: assert property (RVALID && (rd_word_q == 6'h02 || (rd_word_q >= 6'h08 && rd_word_q <= 6'h3C))
    |-> RDATA == 32'h0000_0000)
    else $error("reserved offset read nonzero");
  chk_csw_size: assert property (RVALID && rd_word_q == 6'h00 |-> RDATA[2:0] == 3'h2)
    else $error("control word size field wrong");
  chk_read_okay: assert property (RVALID |-> RRESP == 2'h0)
    else $error("read answered with an error code");
  chk_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] (BVALID && BRESP == 2'h0))
    else $error("write not answered okay");
endmodule // access_port_monitor

bind access_port_regs access_port_monitor #(
  .ADDR_W(ADDR_W), .REVISION(REVISION), .DESIGNER_CONT(DESIGNER_CONT), .DESIGNER_CODE(DESIGNER_CODE),
  .VARIANT(VARIANT), .CONN_TYPE(CONN_TYPE)
) MON (
  .CLK(CLK), .RST(RST), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
  .RRESP(RRESP), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID)
);

/* File: verification/dbg_port_model.sv */
`timescale 1ns/10ps
module dbg_port_model (
  input  wire        CLK,     // clock
  output reg  [7:0]  AWADDR,  // write address
  output reg         AWVALID, // write address valid
  input  wire        AWREADY, // address taken
  output reg  [31:0] WDATA,   // write data
  output reg  [3:0]  WSTRB,   // byte strobes
  output reg         WVALID,  // write data valid
  input  wire        WREADY,  // data taken
  input  wire        BVALID,  // write answer
  output reg         BREADY,  // write answer ready
  output reg  [7:0]  ARADDR,  // read address
  output reg         ARVALID, // read address valid
  input  wire        ARREADY, // read taken
  input  wire [31:0] RDATA,   // read data
  input  wire        RVALID,  // read answer
  output reg         RREADY   // read answer ready
);
  reg hang; // a transfer ran out of time
  initial begin
    {AWADDR, AWVALID, WDATA, WSTRB, WVALID, BREADY, ARADDR, ARVALID, RREADY} = 57'h0;
    hang = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // an all-zero identity word means nothing answers at this selection
  function port_present(input [31:0] id);
    port_present = id != 32'h0000_0000;
  endfunction
  // zero designer field names the original designer; old parts read zero revision and class too
  function origin_designer(input [31:0] id);
    origin_designer = id[27:17] == 11'h000;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // one transfer; bounded so a dead slave cannot hang the run
  task automatic xfer(input wr, input [7:0] a, input [31:0] d, output [31:0] q);
    integer n;
    reg     got;
    begin
      got = 1'b0;
      q   = 32'h0000_0000;
      @(posedge CLK);
      if (wr) begin
        {AWADDR, WDATA, WSTRB} <= {a, d, 4'hF};
        {AWVALID, WVALID, BREADY} <= 3'b111;
      end else begin
        ARADDR <= a;
        {ARVALID, RREADY} <= 2'b11;
      end
      for (n = 0; n < 50 && !got; n = n + 1) begin
        @(posedge CLK);
        // a taken half is dropped and its payload inverted, so nothing stale looks valid
        if (AWVALID && AWREADY) {AWVALID, AWADDR} <= {1'b0, ~AWADDR};
        if (WVALID && WREADY) {WVALID, WDATA} <= {1'b0, ~WDATA};
        if (ARVALID && ARREADY) {ARVALID, ARADDR} <= {1'b0, ~ARADDR};
        if ((BVALID && BREADY) || (RVALID && RREADY)) begin
          q = RDATA;
          {BREADY, RREADY} <= 2'b00;
          got = 1'b1;
        end
      end
      hang = hang | !got;
    end
  endtask
endmodule // dbg_port_model
